// ---- pkg/hbp_pkg.sv ----
// Shared constants and carrier types of the host bus port
`default_nettype none
package hbp_pkg;

  // Host data bus width and the width of one word lane
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;

  // Direct register word addresses: 0x00, 0x04, 0x08, 0x0C
  localparam logic [1:0] ADR_IND_PTR = 2'h0;
  localparam logic [1:0] ADR_IND_DATA = 2'h1;
  localparam logic [1:0] ADR_CDATA = 2'h2;
  localparam logic [1:0] ADR_STATUS = 2'h3;

  // Acknowledge wait counter width and default wait-cycle count
  localparam int WAIT_W = 4;
  localparam logic [WAIT_W-1:0] ACK_WAIT_DEF = 4'h1;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
  localparam logic [WAIT_W-1:0] WAIT_ONE = 4'h1;

  // Reset values of registered data
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

  // Host control pins, all strobes and enables active low
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic low_word_lane_enable_n;
    logic high_word_lane_enable_n;
    logic [1:0] adr;
  } hbp_host_ctl_s;

  // One register write towards the core, valid for one cycle
  typedef struct packed {
    logic valid;
    logic [1:0] adr;
    logic low_lane;
    logic high_lane;
    logic [DATA_W-1:0] data;
  } hbp_reg_wr_s;

  // Register read request towards the core, a level while the read lasts
  typedef struct packed {
    logic active;
    logic [1:0] adr;
    logic low_lane;
    logic high_lane;
  } hbp_reg_rd_s;

  // Access handshake states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_ACK
  } hbp_state_e;

endpackage

`default_nettype wire

// ---- core/hbp_host_port.sv ----
// Host bus port: strobe decode, acknowledge, write capture and pointer advance
// Operation
// - 32-bit two-way host data bus
// - Two address bits pick four direct registers
// - Low lanes gate low word, high lanes high; reads here drive all 32 data lines whatever the lanes
// - FIFO location advances after high lane access
// - Indirect pointer advances after high word access
// - Controls honoured only while chip select low
// - Chip select high releases all data lines
// - Write data captured at write strobe rising
// - Read lasts while read strobe is low
// - Acknowledge marks completion; host waits for it
// - Decode with full FIFO withholds acknowledge
// - Encode with empty FIFO withholds acknowledge
`timescale 1ns/1ps
`default_nettype none

module hbp_host_port #(
  parameter logic [hbp_pkg::WAIT_W-1:0] ACK_WAIT = hbp_pkg::ACK_WAIT_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire hbp_pkg::hbp_host_ctl_s host_ctl_in,
  input wire logic [hbp_pkg::DATA_W-1:0] host_data_in,
  output logic [hbp_pkg::DATA_W-1:0] host_data_out,
  output logic [hbp_pkg::DATA_W-1:0] host_data_oe_out,
  output logic ack_n_out,
  input wire logic encode_mode_in,
  input wire logic fifo_full_in,
  input wire logic fifo_empty_in,
  input wire logic [hbp_pkg::DATA_W-1:0] reg_rdata_in,
  output hbp_pkg::hbp_reg_rd_s reg_rd_out,
  output hbp_pkg::hbp_reg_wr_s reg_wr_out,
  output logic fifo_adv_out,
  output logic ind_adv_out
);

  // Zero wait cycles would acknowledge before read data is registered
  if (ACK_WAIT == hbp_pkg::WAIT_ZERO)
  begin : g_wait_check
    $error("ACK_WAIT must be at least one cycle");
  end

  // Current qualified strobes
  logic cs_act; // Chip select asserted
  logic rd_act; // Read in progress
  logic wr_act; // Write strobe low
  logic access; // Any access in progress
  logic stall; // FIFO cannot serve this access yet
  logic hi_lane; // High word lane enabled now
  logic lo_lane; // Low word lane enabled now

  // Registered state
  hbp_pkg::hbp_host_ctl_s ctl_prev_reg; // Controls seen last cycle
  hbp_pkg::hbp_state_e state_reg; // Handshake state
  hbp_pkg::hbp_state_e state_next;
  logic [hbp_pkg::WAIT_W-1:0] wait_reg; // Wait cycles spent
  logic [hbp_pkg::WAIT_W-1:0] wait_next;
  logic hi_seen_reg; // High lane used during this access
  logic hi_seen_next;
  logic [hbp_pkg::DATA_W-1:0] rdata_reg; // Data driven on reads
  logic [hbp_pkg::DATA_W-1:0] rdata_next;
  hbp_pkg::hbp_reg_wr_s wr_reg; // Write towards the core
  hbp_pkg::hbp_reg_wr_s wr_next;
  logic fifo_adv_reg; // FIFO advance pulse
  logic fifo_adv_next;
  logic ind_adv_reg; // Indirect pointer advance pulse
  logic ind_adv_next;

  // Previous-cycle strobes and end-of-access events
  logic prev_rd;
  logic prev_wr;
  logic wr_end;
  logic rd_end;
  logic acc_end;

  // Strobe qualification; nothing counts unless chip select is low
  always_comb
  begin
    cs_act = !host_ctl_in.cs_n;
    rd_act = cs_act && !host_ctl_in.rd_n;
    wr_act = cs_act && !host_ctl_in.wr_n;
    access = rd_act || wr_act;
    lo_lane = !host_ctl_in.low_word_lane_enable_n;
    hi_lane = !host_ctl_in.high_word_lane_enable_n;
    // Compressed data waits on FIFO room in decode, FIFO data in encode
    stall = (host_ctl_in.adr == hbp_pkg::ADR_CDATA) &&
            ((wr_act && !encode_mode_in && fifo_full_in) ||
             (rd_act && encode_mode_in && fifo_empty_in));
    prev_rd = !ctl_prev_reg.cs_n && !ctl_prev_reg.rd_n;
    prev_wr = !ctl_prev_reg.cs_n && !ctl_prev_reg.wr_n;
    // Rising write strobe while the host still holds select, data and address
    wr_end = prev_wr && host_ctl_in.wr_n && cs_act;
    rd_end = prev_rd && !rd_act;
    acc_end = wr_end || rd_end;
  end

  // Handshake next state: one wait cycle minimum, then hold until served
  always_comb
  begin
    state_next = state_reg;
    wait_next = wait_reg;
    case (state_reg)
      hbp_pkg::ST_IDLE:
      begin
        // New access begins the wait period
        if (access)
        begin
          state_next = hbp_pkg::ST_WAIT;
          wait_next = hbp_pkg::WAIT_ONE;
        end
      end
      hbp_pkg::ST_WAIT:
      begin
        // Host gave up early: drop back without acknowledging
        if (!access)
        begin
          state_next = hbp_pkg::ST_IDLE;
        end
        else if (wait_reg >= ACK_WAIT && !stall)
        begin
          state_next = hbp_pkg::ST_ACK;
        end
        else if (wait_reg < ACK_WAIT)
        begin
          wait_next = wait_reg + hbp_pkg::WAIT_ONE;
        end
      end
      hbp_pkg::ST_ACK:
      begin
        // Acknowledge stands until the host ends the access
        if (!access)
        begin
          state_next = hbp_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_next = hbp_pkg::ST_IDLE;
      end
    endcase
  end

  // Handshake registers; clock enable freezes everything
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= hbp_pkg::ST_IDLE;
      wait_reg <= hbp_pkg::WAIT_ZERO;
    end
    else if (ce_in)
    begin
      state_reg <= state_next;
      wait_reg <= wait_next;
    end
  end

  // Data path next values: read data, write capture, pointer advance
  always_comb
  begin
    rdata_next = rdata_reg;
    wr_next = '0;
    fifo_adv_next = 1'b0;
    ind_adv_next = 1'b0;
    hi_seen_next = hi_seen_reg;
    // Keep read data fresh from the core for the whole low strobe
    if (rd_act)
    begin
      rdata_next = reg_rdata_in;
    end
    // Remember that the high word took part; a 32-bit host always has it
    if (access && hi_lane)
    begin
      hi_seen_next = 1'b1;
    end
    // Write lands at the strobe edge; compressed data only once served
    if (wr_end && (ctl_prev_reg.adr != hbp_pkg::ADR_CDATA || state_reg == hbp_pkg::ST_ACK))
    begin
      wr_next.valid = 1'b1;
      wr_next.adr = ctl_prev_reg.adr;
      wr_next.low_lane = !ctl_prev_reg.low_word_lane_enable_n;
      wr_next.high_lane = !ctl_prev_reg.high_word_lane_enable_n;
      wr_next.data = host_data_in;
    end
    // Advance only after an acknowledged access that touched the high word
    if (acc_end)
    begin
      hi_seen_next = 1'b0;
      if (hi_seen_reg && state_reg == hbp_pkg::ST_ACK)
      begin
        if (ctl_prev_reg.adr == hbp_pkg::ADR_CDATA)
        begin
          fifo_adv_next = 1'b1;
        end
        else if (ctl_prev_reg.adr == hbp_pkg::ADR_IND_DATA)
        begin
          ind_adv_next = 1'b1;
        end
      end
    end
    else if (!cs_act)
    begin
      hi_seen_next = 1'b0;
    end
  end

  // Data path registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ctl_prev_reg <= '1;
      rdata_reg <= hbp_pkg::DATA_RST;
      wr_reg <= '0;
      fifo_adv_reg <= 1'b0;
      ind_adv_reg <= 1'b0;
      hi_seen_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      ctl_prev_reg <= host_ctl_in;
      rdata_reg <= rdata_next;
      wr_reg <= wr_next;
      fifo_adv_reg <= fifo_adv_next;
      ind_adv_reg <= ind_adv_next;
      hi_seen_reg <= hi_seen_next;
    end
  end

  // Output drive; enables are combinational so the bus frees at once
  always_comb
  begin
    host_data_out = rdata_reg;
    // Driving only on selected reads avoids fighting host write data
    host_data_oe_out = rd_act ? '1 : '0;
    ack_n_out = !(state_reg == hbp_pkg::ST_ACK && access);
    reg_rd_out.active = rd_act;
    reg_rd_out.adr = host_ctl_in.adr;
    reg_rd_out.low_lane = lo_lane;
    reg_rd_out.high_lane = hi_lane;
    reg_wr_out = wr_reg;
    fifo_adv_out = fifo_adv_reg;
    ind_adv_out = ind_adv_reg;
  end

endmodule

`default_nettype wire

// ---- verif/hbp_host_port_sva.sv ----
// Checker of the host bus port handshake
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port_sva #(
  parameter logic [hbp_pkg::WAIT_W-1:0] ACK_WAIT = hbp_pkg::ACK_WAIT_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire hbp_pkg::hbp_host_ctl_s host_ctl_in,
  input wire logic [hbp_pkg::DATA_W-1:0] host_data_in,
  input wire logic [hbp_pkg::DATA_W-1:0] host_data_out,
  input wire logic [hbp_pkg::DATA_W-1:0] host_data_oe_out,
  input wire logic ack_n_out,
  input wire logic encode_mode_in,
  input wire logic fifo_full_in,
  input wire logic fifo_empty_in,
  input wire logic [hbp_pkg::DATA_W-1:0] reg_rdata_in,
  input wire hbp_pkg::hbp_reg_rd_s reg_rd_out,
  input wire hbp_pkg::hbp_reg_wr_s reg_wr_out,
  input wire logic fifo_adv_out,
  input wire logic ind_adv_out
);
  localparam int LAT = ACK_WAIT + 1; // Edges from strobe seen to ack seen
  hbp_pkg::hbp_host_ctl_s c; // Short alias of the pins
  logic rd_on; // Selected read
  logic wr_on; // Selected write
  assign c = host_ctl_in;
  assign rd_on = !c.cs_n && !c.rd_n;
  assign wr_on = !c.cs_n && !c.wr_n;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_oe; host_data_oe_out == {hbp_pkg::DATA_W{rd_on}}; endproperty
  a_oe: assert property (p_oe) else $error("data enable wrong");
  property p_idle; c.cs_n |-> ack_n_out && !reg_rd_out.active; endproperty
  a_idle: assert property (p_idle) else $error("deselected port active");
  property p_dec; rd_on |-> reg_rd_out.active && reg_rd_out.adr == c.adr
    && reg_rd_out.low_lane == !c.low_word_lane_enable_n && reg_rd_out.high_lane == !c.high_word_lane_enable_n; endproperty
  a_dec: assert property (p_dec) else $error("read decode wrong");
  property p_rdat; !$past(rst_in) && $past(rd_on) |-> host_data_out == $past(reg_rdata_in); endproperty
  a_rdat: assert property (p_rdat) else $error("read data wrong");
  // FIFO register is left out: its ack may be held off by the flags
  property p_lat; $rose(wr_on || rd_on) && c.adr != hbp_pkg::ADR_CDATA |-> ack_n_out ##LAT !ack_n_out; endproperty
  a_lat: assert property (p_lat) else $error("ack latency wrong");
  property p_swr; $fell(ack_n_out) && wr_on && c.adr == hbp_pkg::ADR_CDATA && !encode_mode_in
    |-> !$past(fifo_full_in); endproperty
  a_swr: assert property (p_swr) else $error("ack into full fifo");
  property p_srd; $fell(ack_n_out) && rd_on && c.adr == hbp_pkg::ADR_CDATA && encode_mode_in
    |-> !$past(fifo_empty_in); endproperty
  a_srd: assert property (p_srd) else $error("ack from empty fifo");
  property p_wr; !ack_n_out && wr_on ##1 c.wr_n |=> reg_wr_out.valid
    && reg_wr_out.data == $past(host_data_in, 2) && reg_wr_out.adr == $past(c.adr, 2); endproperty
  a_wr: assert property (p_wr) else $error("write capture wrong");
  property p_fadv; !ack_n_out && c.adr == hbp_pkg::ADR_CDATA ##1 (c.rd_n && c.wr_n)
    |=> fifo_adv_out == !$past(c.high_word_lane_enable_n, 2); endproperty
  a_fadv: assert property (p_fadv) else $error("fifo advance wrong");
  property p_iadv; !ack_n_out && c.adr == hbp_pkg::ADR_IND_DATA ##1 (c.rd_n && c.wr_n)
    |=> ind_adv_out == !$past(c.high_word_lane_enable_n, 2); endproperty
  a_iadv: assert property (p_iadv) else $error("pointer advance wrong");
  c_stall: cover property (wr_on && ack_n_out && fifo_full_in);
  c_fadv: cover property (fifo_adv_out);
  c_iadv: cover property (ind_adv_out);
endmodule
bind hbp_host_port hbp_host_port_sva #(.ACK_WAIT(ACK_WAIT)) i_sva (.*);
`default_nettype wire

// ---- verif/hbp_host_model.sv ----
// Host processor model that sequences accesses by strobes and the acknowledge
`timescale 1ns/1ps
`default_nettype none
module hbp_host_model (
  input wire logic clk_in,
  input wire logic ack_n_in,
  input wire logic [hbp_pkg::DATA_W-1:0] rdata_in,
  output hbp_pkg::hbp_host_ctl_s ctl_out,
  output logic [hbp_pkg::DATA_W-1:0] data_out
);
  // Idle host: deselected, strobes and lanes off
  initial ctl_out = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0};
  initial data_out = 32'h0000_0000;
  // One access; strobe held until ack, or until the wait bound runs out
  task automatic xfer(input logic wr, input logic [1:0] adr, input logic [1:0] ln,
                      input logic [31:0] wd, output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    @(negedge clk_in);
    ctl_out <= '{1'b0, wr, !wr, ln[0], ln[1], adr};
    data_out <= wd;
    do @(posedge clk_in); while (ack_n_in !== 1'b0 && n++ < 40);
    q = rdata_in;
    ok = ack_n_in === 1'b0;
    @(negedge clk_in);
    ctl_out.rd_n <= 1'b1;
    ctl_out.wr_n <= 1'b1;
    @(negedge clk_in);
    ctl_out.cs_n <= 1'b1;
    data_out <= ~wd; // Released bus must not keep showing the old word
  endtask
endmodule
`default_nettype wire

// ---- verif/hbp_host_port_tb.sv ----
// Self-checking bench of the host bus port
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port_tb;
  typedef struct {logic wr; logic [1:0] adr; logic [1:0] ln; logic [31:0] d;} hbp_row_s;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic enc = 1'b0;
  logic full = 1'b0;
  logic empty = 1'b0;
  logic [31:0] rdata = 32'h0;
  logic [31:0] hdin, hdout, oe, q, last_wr;
  logic [3:0] last_ctl; // Address and lane-off bits of the last write pulse
  logic ack_n, ok, fadv, iadv;
  hbp_pkg::hbp_host_ctl_s ctl;
  hbp_pkg::hbp_reg_wr_s wr_s;
  int err_total = 0;
  int checked = 0;
  int nf = 0;
  int ni = 0;
  // Lane pair ln: bit 0 low lane off, bit 1 high lane off
  hbp_row_s rows [7] = '{'{1'b1, 2'h0, 2'h0, 32'h1234_5678}, '{1'b1, 2'h1, 2'h2, 32'h0000_A5A5},
    '{1'b1, 2'h1, 2'h1, 32'h5A5A_0000}, '{1'b1, 2'h2, 2'h0, 32'hDEAD_BEEF}, '{1'b0, 2'h2, 2'h2, 32'h0F0F_F0F0},
    '{1'b0, 2'h2, 2'h1, 32'hF0F0_0F0F}, '{1'b0, 2'h3, 2'h0, 32'h8001_7FFE}};
  hbp_host_port i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .host_ctl_in(ctl), .host_data_in(hdin),
    .host_data_out(hdout), .host_data_oe_out(oe), .ack_n_out(ack_n), .encode_mode_in(enc), .fifo_full_in(full),
    .fifo_empty_in(empty), .reg_rdata_in(rdata), .reg_rd_out(), .reg_wr_out(wr_s), .fifo_adv_out(fadv),
    .ind_adv_out(iadv));
  hbp_host_model i_host (.clk_in(clk_in), .ack_n_in(ack_n), .rdata_in(hdout), .ctl_out(ctl), .data_out(hdin));
  always #12.5 clk_in = ~clk_in;
  // Advance pulses counted and last written word kept
  always @(posedge clk_in)
  begin
    if (fadv === 1'b1) nf++;
    if (iadv === 1'b1) ni++;
    if (wr_s.valid === 1'b1) last_wr <= wr_s.data;
    if (wr_s.valid === 1'b1) last_ctl <= {wr_s.adr, !wr_s.high_lane, !wr_s.low_lane};
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One access, then data and advance counts against expectation
  task automatic run(input hbp_row_s r);
    int f0, i0;
    f0 = nf;
    i0 = ni;
    rdata = r.d;
    i_host.xfer(r.wr, r.adr, r.ln, r.d, q, ok);
    repeat (2) @(negedge clk_in);
    chk({31'h0, ok}, 32'h1);
    chk(r.wr ? last_wr : q, r.d);
    if (r.wr) chk({28'h0, last_ctl}, {28'h0, r.adr, r.ln});
    chk(nf - f0, r.adr == hbp_pkg::ADR_CDATA && !r.ln[1]);
    chk(ni - i0, r.adr == hbp_pkg::ADR_IND_DATA && !r.ln[1]);
  endtask
  task automatic final_report;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    chk({31'h0, ack_n}, 32'h1);
    chk(oe, 32'h0);
    foreach (rows[i]) run(rows[i]);
    // Decode write into a full FIFO, then encode read from an empty one
    for (int m = 0; m < 2; m++)
    begin
      enc = m[0];
      full = !m[0];
      empty = m[0];
      fork
        run('{!m[0], 2'h2, 2'h0, 32'hC3C3_3C3C});
        begin
          repeat (6) @(negedge clk_in);
          chk({31'h0, ack_n}, 32'h1);
          full = 1'b0;
          empty = 1'b0;
        end
      join
    end
    // Reset in mid-run clears read data and pulses; port works right after
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    chk(hdout, hbp_pkg::DATA_RST);
    chk({30'h0, fadv, wr_s.valid}, 32'h0);
    chk({31'h0, ack_n}, 32'h1);
    run(rows[0]);
    // Read strobe without chip select must stay ignored
    i_host.ctl_out.rd_n <= 1'b0;
    repeat (3) @(negedge clk_in);
    chk(oe, 32'h0);
    chk({31'h0, ack_n}, 32'h1);
    i_host.ctl_out.rd_n <= 1'b1;
    @(negedge clk_in);
    final_report;
  end
  // Whole run needs about 92 cycles; a hang is cut off well past that
  initial
  begin
    repeat (3000) @(posedge clk_in);
    err_total++;
    final_report;
  end
endmodule
`default_nettype wire
